/* File: rtl/rpc_pkg.sv */
// Constants, register map and types for the reset, power and chop control
// How it works
// - Reset pin low or supply fault halts logic; oscillator keeps running.
// - Entering reset clears every control register bit to zero.
// - Reset lasts until timer done, 4100 slow clock ticks after pin release.
// - On timer expiry the processor fetches preboot, then boot, from zero.
// - Power-up timer starts once supply exceeds threshold, 4100 ticks.
// - After release a preboot phase of exactly 32 cycles precedes boot.
// - Below threshold, clock, oscillator, RAM and watchdog flag use battery.
// - Power-save bits stop engine, converter, test clock, boost, monitor.
// - Fast flash bit shortens the flash read pulse to 33 ns.
// - Emulator clock off bit stops that clock and blocks the debug port.
// - Processor clock divider: larger settings give slower processor clock.
// - Firmware writes 4, 5 or 6 to fuse select, then reads fuse value.
// - Mode 0: engine computes gain word from coefficients and reference.
// - Mode 15: engine uses firmware gain word and ignores coefficients.
// - Chop high reverses reference amplifier inputs; low keeps positive.
// - Chop field 00 or 11 toggles polarity every non-alternate multiplexer cycle.
// - Chop field 01 holds positive; field 10 holds reversed.
// - An alternate cycle request inserts one alternate multiplexer cycle.
// - Under automatic chopping alternate cycles always run positive.
// - Chop field written after transfer done holds all the next cycle.
// - Engine and transfer interrupts fire on falling edges of busy signals.
package rpc_pkg;

    // Register offsets
    localparam logic [15:0] OFS_GAIN_ADJUST_WORD   = 16'h002e;
    localparam logic [15:0] OFS_COMP_MODE  = 16'h0038;
    localparam logic [15:0] OFS_LIN_COEFF  = 16'h0039;
    localparam logic [15:0] OFS_SQ_COEFF   = 16'h003a;
    localparam logic [15:0] OFS_TEMP_REF   = 16'h003b;
    localparam logic [15:0] OFS_PWR_CTRL   = 16'h2000;
    localparam logic [15:0] OFS_STATUS     = 16'h2001;
    localparam logic [15:0] OFS_FUSE_SEL   = 16'h20fd;
    localparam logic [15:0] OFS_FUSE_VAL   = 16'h20ff;

    // Power control field positions
    localparam int B_CE_EN      = 0;
    localparam int B_ADC_OFF    = 1;
    localparam int B_CKOUT_OFF  = 2;
    localparam int B_ECK_OFF    = 3;
    localparam int B_FAST_FLASH = 4;
    localparam int B_BOOST_ON   = 5;
    localparam int B_MON_ON     = 6;
    localparam int B_ALT_REQ    = 7;
    localparam int B_CHOP_LO    = 8;
    localparam int B_DIV_LO     = 12;

    // Fuse selectors and compensation modes
    localparam logic [7:0]  FUSE_SEL_SLOPE = 8'h04;
    localparam logic [7:0]  FUSE_SEL_BGA   = 8'h05;
    localparam logic [7:0]  FUSE_SEL_BGB   = 8'h06;
    localparam logic [31:0] COMP_INTERNAL  = 32'h0000_0000;
    localparam logic [31:0] COMP_EXTERNAL  = 32'h0000_000f;

    // Chop field encodings
    localparam logic [1:0] CHOP_POS = 2'b01;
    localparam logic [1:0] CHOP_REV = 2'b10;

    // Timing
    localparam int RESET_TICKS_DEF = 4100;
    localparam int PREBOOT_CYCLES  = 32;
    localparam int CLK_MHZ         = 100;
    localparam int FAST_FLASH_NS   = 33;
    localparam int FAST_FLASH_CYC  = (FAST_FLASH_NS * CLK_MHZ + 999) / 1000;
    localparam int SLOW_FLASH_CYC  = 7;

    // Gain computation scaling
    localparam logic signed [49:0] GAIN_UNITY = 50'sh0000_0040_0000;
    localparam int LIN_SHIFT = 8;
    localparam int SQ_SHIFT  = 16;

    // Reset sequence states, Gray along the path
    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_TIMER   = 2'b01,
        ST_PREBOOT = 2'b11,
        ST_RUN     = 2'b10
    } rpc_state_e;

    // Power-save gate outputs
    typedef struct packed {
        logic       engine_on;
        logic       converter_on;
        logic       test_clock_on;
        logic       emulator_clock_on;
        logic       display_boost_on;
        logic       monitor_stream_on;
        logic       fast_flash_read_pulse;
        logic [2:0] flash_pulse_cycles;
    } rpc_gate_s;

endpackage : rpc_pkg

/* File: rtl/rpc_top.sv */
// Reset sequencer, power gating, fuse readout, compensation and chop control
`timescale 1ns/1ps
module rpc_top import rpc_pkg::*; #(
    parameter int RESET_TICKS = RESET_TICKS_DEF
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // Pins and slow clock
    input  wire logic        ext_reset_low_pin_n_in,
    input  wire logic        power_fault_above_in,
    input  wire logic        rtc_clock_in,
    input  wire logic        watchdog_overflow_in,
    // Engine side, same clock
    input  wire logic        mux_cycle_end_in,
    input  wire logic        engine_busy_in,
    input  wire logic        transfer_busy_in,
    input  wire logic [15:0] die_temp_in,
    // Fuses
    input  wire logic [7:0]  bandgap_fuse_a_in,
    input  wire logic [7:0]  bandgap_fuse_b_in,
    input  wire logic [2:0]  slope_fuse_in,
    // Register port
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    // Sequencer outputs
    output logic             digital_halt_out,
    output logic             cpu_reset_out,
    output logic             preboot_out,
    output logic             timer_done_out,
    output logic      [15:0] boot_addr_out,
    output logic             battery_hold_out,
    output logic             watchdog_overflow_flag_out,
    // Gating and clocks
    output rpc_gate_s        gate_out,
    output logic             cpu_clk_tick_out,
    // Engine controls
    output logic      [31:0] gain_applied_out,
    output logic             chop_reversed_out,
    output logic             alt_cycle_out,
    output logic             engine_irq_out,
    output logic             transfer_irq_out
);

    // Pin synchronisers
    logic [1:0] pin_sync_r;
    logic [1:0] pwr_sync_r;
    logic [2:0] rtc_sync_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pin_sync_r <= 2'b00;
            pwr_sync_r <= 2'b00;
            rtc_sync_r <= 3'b000;
        end else begin
            pin_sync_r <= {pin_sync_r[0], ext_reset_low_pin_n_in};
            pwr_sync_r <= {pwr_sync_r[0], power_fault_above_in};
            rtc_sync_r <= {rtc_sync_r[1:0], rtc_clock_in};
        end
    end

    logic hold_req;
    logic rtc_tick;
    assign hold_req = !pin_sync_r[1] || !pwr_sync_r[1];
    // Edge taken from synchronised stages only
    assign rtc_tick = rtc_sync_r[1] && !rtc_sync_r[2];

    // Reset sequence state machine
    rpc_state_e state_r;
    logic [12:0] tick_cnt_r;
    logic [5:0]  pre_cnt_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_r    <= ST_HOLD;
            tick_cnt_r <= 13'h0000;
            pre_cnt_r  <= 6'h00;
        end else if (hold_req) begin
            state_r    <= ST_HOLD;
            tick_cnt_r <= 13'h0000;
            pre_cnt_r  <= 6'h00;
        end else begin
            unique case (state_r)
                ST_HOLD: begin
                    state_r <= ST_TIMER;
                end
                ST_TIMER: begin
                    if (rtc_tick) begin
                        if (tick_cnt_r == 13'(RESET_TICKS - 1)) begin
                            state_r <= ST_PREBOOT;
                        end
                        tick_cnt_r <= tick_cnt_r + 13'h0001;
                    end
                end
                ST_PREBOOT: begin
                    if (pre_cnt_r == 6'(PREBOOT_CYCLES - 1)) begin
                        state_r <= ST_RUN;
                    end
                    pre_cnt_r <= pre_cnt_r + 6'h01;
                end
                ST_RUN: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

    logic in_reset;
    assign in_reset = (state_r == ST_HOLD) || (state_r == ST_TIMER);
    // Expiry never counts while a new hold is pending
    logic expire;
    assign expire = state_r == ST_TIMER && rtc_tick && !hold_req
                    && tick_cnt_r == 13'(RESET_TICKS - 1);

    // Sequencer outputs, registered
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            digital_halt_out <= 1'b1;
            cpu_reset_out    <= 1'b1;
            preboot_out      <= 1'b0;
            timer_done_out   <= 1'b0;
            battery_hold_out <= 1'b1;
            boot_addr_out    <= 16'h0000;
        end else begin
            digital_halt_out <= hold_req;
            cpu_reset_out    <= hold_req || (in_reset && !expire);
            timer_done_out   <= !hold_req && (!in_reset || expire);
            preboot_out      <= expire || (state_r == ST_PREBOOT && !hold_req
                                && pre_cnt_r != 6'(PREBOOT_CYCLES - 1));
            battery_hold_out <= !pwr_sync_r[1];
            boot_addr_out    <= 16'h0000;
        end
    end

    // Watchdog flag lives on battery: never cleared by chip reset
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            watchdog_overflow_flag_out <= 1'b0;
        end else if (watchdog_overflow_in) begin
            watchdog_overflow_flag_out <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == OFS_STATUS
                     && reg_wdata_in[0]) begin
            watchdog_overflow_flag_out <= 1'b0;
        end
    end

    // Control registers, cleared while the chip is in reset
    logic [31:0] pwr_ctrl_r;
    logic [31:0] comp_mode_r;
    logic [31:0] gain_fw_r;
    logic [31:0] lin_coeff_r;
    logic [31:0] sq_coeff_r;
    logic [31:0] temp_ref_r;
    logic [7:0]  fuse_sel_r;
    logic        alt_taken;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_ctrl_r  <= 32'h0000_0000;
            comp_mode_r <= 32'h0000_0000;
            gain_fw_r   <= 32'h0000_0000;
            lin_coeff_r <= 32'h0000_0000;
            sq_coeff_r  <= 32'h0000_0000;
            temp_ref_r  <= 32'h0000_0000;
            fuse_sel_r  <= 8'h00;
        end else if (in_reset) begin
            pwr_ctrl_r  <= 32'h0000_0000;
            comp_mode_r <= 32'h0000_0000;
            gain_fw_r   <= 32'h0000_0000;
            lin_coeff_r <= 32'h0000_0000;
            sq_coeff_r  <= 32'h0000_0000;
            temp_ref_r  <= 32'h0000_0000;
            fuse_sel_r  <= 8'h00;
        end else begin
            if (reg_wr_in) begin
                unique case (reg_addr_in)
                    OFS_PWR_CTRL:  pwr_ctrl_r  <= reg_wdata_in & 32'h0000_73ff;
                    OFS_COMP_MODE: comp_mode_r <= reg_wdata_in;
                    OFS_LIN_COEFF: lin_coeff_r <= reg_wdata_in;
                    OFS_SQ_COEFF:  sq_coeff_r  <= reg_wdata_in;
                    OFS_TEMP_REF:  temp_ref_r  <= reg_wdata_in;
                    OFS_FUSE_SEL:  fuse_sel_r  <= reg_wdata_in[7:0];
                    // Gain word is only an input in external mode
                    OFS_GAIN_ADJUST_WORD: begin
                        if (comp_mode_r == COMP_EXTERNAL) begin
                            gain_fw_r <= reg_wdata_in;
                        end
                    end
                    default: ;
                endcase
            end
            // Request consumed when the alternate cycle starts; set wins
            if (alt_taken && !(reg_wr_in && reg_addr_in == OFS_PWR_CTRL
                               && reg_wdata_in[B_ALT_REQ])) begin
                pwr_ctrl_r[B_ALT_REQ] <= 1'b0;
            end
        end
    end

    // Gain from coefficients and die temperature
    logic signed [49:0] dt_w;
    logic signed [49:0] lin_p;
    logic signed [49:0] sq_p;
    logic        [31:0] gain_calc;
    always_comb begin
        dt_w  = 50'($signed(die_temp_in)) - 50'($signed(temp_ref_r[15:0]));
        lin_p = 50'(50'($signed(lin_coeff_r[15:0])) * dt_w);
        sq_p  = 50'(50'($signed(sq_coeff_r[15:0]))
                * 50'((50'(dt_w * dt_w)) >>> SQ_SHIFT));
        gain_calc = 32'(GAIN_UNITY + (lin_p >>> LIN_SHIFT)
                    + (sq_p >>> SQ_SHIFT));
    end

    // Gain applied by the engine, updated once per multiplexer cycle in internal mode while the engine is enabled, every clock in external mode
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gain_applied_out <= 32'h0000_0000;
        end else if (in_reset) begin
            gain_applied_out <= 32'h0000_0000;
        end else if (comp_mode_r == COMP_EXTERNAL) begin
            gain_applied_out <= gain_fw_r;
        end else if (comp_mode_r == COMP_INTERNAL && mux_cycle_end_in
                     && pwr_ctrl_r[B_CE_EN]) begin
            gain_applied_out <= gain_calc;
        end
    end

    // Chop polarity and alternate cycle sequencing
    logic       toggle_r;
    logic [1:0] chop_fld;
    assign chop_fld  = pwr_ctrl_r[B_CHOP_LO +: 2];
    assign alt_taken = mux_cycle_end_in && pwr_ctrl_r[B_ALT_REQ];
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            toggle_r          <= 1'b0;
            chop_reversed_out <= 1'b0;
            alt_cycle_out     <= 1'b0;
        end else if (in_reset) begin
            toggle_r          <= 1'b0;
            chop_reversed_out <= 1'b0;
            alt_cycle_out     <= 1'b0;
        end else if (mux_cycle_end_in) begin
            // Field sampled only at the boundary, held all cycle
            alt_cycle_out <= pwr_ctrl_r[B_ALT_REQ];
            if (chop_fld == CHOP_POS) begin
                chop_reversed_out <= 1'b0;
            end else if (chop_fld == CHOP_REV) begin
                chop_reversed_out <= 1'b1;
            end else if (pwr_ctrl_r[B_ALT_REQ]) begin
                // Toggle sequence resumes after the alternate cycle
                chop_reversed_out <= 1'b0;
            end else begin
                toggle_r          <= !toggle_r;
                chop_reversed_out <= !toggle_r;
            end
        end
    end

    // Falling-edge interrupts from the busy lines
    logic eng_busy_d_r;
    logic xfr_busy_d_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            eng_busy_d_r     <= 1'b0;
            xfr_busy_d_r     <= 1'b0;
            engine_irq_out   <= 1'b0;
            transfer_irq_out <= 1'b0;
        end else begin
            eng_busy_d_r     <= engine_busy_in;
            xfr_busy_d_r     <= transfer_busy_in;
            engine_irq_out   <= eng_busy_d_r && !engine_busy_in;
            transfer_irq_out <= xfr_busy_d_r && !transfer_busy_in;
        end
    end

    // Power-save gates, registered
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            gate_out <= '0;
        end else begin
            gate_out.engine_on         <= pwr_ctrl_r[B_CE_EN] && !in_reset;
            gate_out.converter_on      <= !pwr_ctrl_r[B_ADC_OFF];
            gate_out.test_clock_on     <= !pwr_ctrl_r[B_CKOUT_OFF];
            // Debug port, erase and programming all lost when set
            gate_out.emulator_clock_on <= !pwr_ctrl_r[B_ECK_OFF]
                                          && !preboot_out;
            gate_out.display_boost_on  <= pwr_ctrl_r[B_BOOST_ON];
            gate_out.monitor_stream_on <= pwr_ctrl_r[B_MON_ON];
            gate_out.fast_flash_read_pulse <= pwr_ctrl_r[B_FAST_FLASH];
            gate_out.flash_pulse_cycles <= pwr_ctrl_r[B_FAST_FLASH]
                ? 3'(FAST_FLASH_CYC) : 3'(SLOW_FLASH_CYC);
        end
    end

    // Processor clock enable: one tick every divider+1 cycles
    logic [2:0] div_cnt_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt_r        <= 3'h0;
            cpu_clk_tick_out <= 1'b0;
        end else if (div_cnt_r >= pwr_ctrl_r[B_DIV_LO +: 3]) begin
            div_cnt_r        <= 3'h0;
            cpu_clk_tick_out <= !in_reset;
        end else begin
            div_cnt_r        <= div_cnt_r + 3'h1;
            cpu_clk_tick_out <= 1'b0;
        end
    end

    // Fuse selection
    logic [7:0] fuse_val;
    always_comb begin
        unique case (fuse_sel_r)
            FUSE_SEL_SLOPE: fuse_val = {5'h00, slope_fuse_in};
            FUSE_SEL_BGA:   fuse_val = bandgap_fuse_a_in;
            FUSE_SEL_BGB:   fuse_val = bandgap_fuse_b_in;
            default:        fuse_val = 8'h00;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                OFS_PWR_CTRL:  reg_rdata_out <= pwr_ctrl_r;
                OFS_STATUS:    reg_rdata_out <= {26'h0, state_r, preboot_out,
                                   alt_cycle_out, chop_reversed_out,
                                   watchdog_overflow_flag_out};
                OFS_COMP_MODE: reg_rdata_out <= comp_mode_r;
                OFS_LIN_COEFF: reg_rdata_out <= lin_coeff_r;
                OFS_SQ_COEFF:  reg_rdata_out <= sq_coeff_r;
                OFS_TEMP_REF:  reg_rdata_out <= temp_ref_r;
                OFS_GAIN_ADJUST_WORD:  reg_rdata_out <= gain_applied_out;
                OFS_FUSE_SEL:  reg_rdata_out <= {24'h0, fuse_sel_r};
                OFS_FUSE_VAL:  reg_rdata_out <= {24'h0, fuse_val};
                default:       reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end

    // Preboot length helper for checking
    logic [6:0] pre_len_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pre_len_r <= 7'h00;
        end else if (preboot_out) begin
            pre_len_r <= pre_len_r + 7'h01;
        end else begin
            pre_len_r <= 7'h00;
        end
    end

    AST_HALT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        hold_req |=> digital_halt_out && cpu_reset_out)
        else $error("halt missing while reset held");

    AST_CLEAR: assert property (@(posedge clk_in) disable iff (!nrst_in)
        in_reset |=> pwr_ctrl_r == 32'h0 && comp_mode_r == 32'h0)
        else $error("registers not cleared in reset");

    AST_EXPIRE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_r == ST_TIMER && rtc_tick && !hold_req
        && tick_cnt_r == 13'(RESET_TICKS - 1)
        |=> !cpu_reset_out && timer_done_out && preboot_out)
        else $error("timer expiry did not release reset");

    AST_BOOT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(cpu_reset_out) |-> boot_addr_out == 16'h0000)
        else $error("boot address not zero");

    AST_PREBOOT: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(preboot_out) && !hold_req && !$past(hold_req)
        |-> pre_len_r == 7'(PREBOOT_CYCLES))
        else $error("preboot length wrong");

    AST_RESTART: assert property (@(posedge clk_in) disable iff (!nrst_in)
        state_r == ST_TIMER && hold_req |=> tick_cnt_r == 13'h0 ##1
        state_r != ST_PREBOOT)
        else $error("timer did not restart");

    AST_BATTERY: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !pwr_sync_r[1] |=> battery_hold_out)
        else $error("battery hold missing");

    AST_FUSE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        reg_rd_in && reg_addr_in == OFS_FUSE_VAL
        && fuse_sel_r == FUSE_SEL_BGA
        |=> reg_rdata_out == {24'h0, $past(bandgap_fuse_a_in)})
        else $error("fuse value mismatch");

    AST_HOLDPOS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mux_cycle_end_in && !in_reset && chop_fld == CHOP_POS
        |=> !chop_reversed_out)
        else $error("positive hold not applied");

    AST_ALTPOS: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mux_cycle_end_in && !in_reset && pwr_ctrl_r[B_ALT_REQ]
        && (chop_fld == 2'b00 || chop_fld == 2'b11)
        |=> alt_cycle_out && !chop_reversed_out)
        else $error("alternate cycle not positive");

    AST_TOGGLE: assert property (@(posedge clk_in) disable iff (!nrst_in)
        mux_cycle_end_in && !in_reset && !pwr_ctrl_r[B_ALT_REQ]
        && chop_fld == 2'b11 |=> chop_reversed_out != $past(toggle_r))
        else $error("auto chop did not toggle");

    AST_IRQ: assert property (@(posedge clk_in) disable iff (!nrst_in)
        $fell(transfer_busy_in) |=> transfer_irq_out ##1 !transfer_irq_out)
        else $error("transfer interrupt not a falling-edge pulse");

endmodule : rpc_top

/* File: testbench/tb_top.sv */
// Self-checking bench for the reset, power and chop control block
`timescale 1ns/1ps
module tb_top;
    import rpc_pkg::*;
    logic clk_in = 0, nrst_in = 0, ext_reset_low_pin_n_in = 1;
    logic power_fault_above_in = 1, mux_cycle_end_in = 0, reg_wr_in = 0;
    logic engine_busy_in = 0, transfer_busy_in = 0, reg_rd_in = 0;
    logic [15:0] reg_addr_in = 16'h0, boot_addr_out;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out, gain_applied_out;
    logic [2:0] rtc_div_r = 3'h0;
    logic rtc_clock_in, digital_halt_out, cpu_reset_out, preboot_out;
    logic timer_done_out, battery_hold_out, watchdog_overflow_flag_out;
    logic cpu_clk_tick_out, chop_reversed_out, alt_cycle_out, p;
    logic engine_irq_out, transfer_irq_out;
    rpc_gate_s gate_out;
    int num_errors = 0, checks = 0, n;
    // Static fuse contents, values picked to differ
    wire [7:0] bandgap_fuse_a_in = 8'ha5, bandgap_fuse_b_in = 8'h3c;
    wire [2:0] slope_fuse_in = 3'h5;
    wire [15:0] die_temp_in = 16'h0000;
    logic watchdog_overflow_in = 1'b0;
    // Short timer count keeps the run brief
    rpc_top #(.RESET_TICKS(5)) uut (.clk_in, .nrst_in, .ext_reset_low_pin_n_in,
        .power_fault_above_in, .rtc_clock_in, .watchdog_overflow_in,
        .mux_cycle_end_in, .engine_busy_in, .transfer_busy_in, .die_temp_in,
        .bandgap_fuse_a_in, .bandgap_fuse_b_in, .slope_fuse_in, .reg_addr_in,
        .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .digital_halt_out, .cpu_reset_out, .preboot_out, .timer_done_out,
        .boot_addr_out, .battery_hold_out, .watchdog_overflow_flag_out,
        .gate_out, .cpu_clk_tick_out, .gain_applied_out, .chop_reversed_out,
        .alt_cycle_out, .engine_irq_out, .transfer_irq_out);
    // Clocks; slow tick every 8 cycles
    always #5 clk_in = ~clk_in;
    always @(posedge clk_in) rtc_div_r <= rtc_div_r + 3'h1;
    assign rtc_clock_in = rtc_div_r[2];
    task automatic final_report();
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(reg_rdata_out, exp);
    endtask : rd
    // One boundary pulse, then let the registered answer land
    task automatic mux();
        @(posedge clk_in);
        mux_cycle_end_in <= 1'b1;
        @(posedge clk_in);
        mux_cycle_end_in <= 1'b0;
        @(posedge clk_in);
        #1;
    endtask : mux
    // Wait for timer expiry, then measure the preboot window
    task automatic boot();
        n = 0;
        while (timer_done_out !== 1'b1 && n < 500) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk(32'(n > 32 && n < 500), 32'h1);
        if (n >= 500) final_report();
        #1 chk({cpu_reset_out, boot_addr_out}, 32'h0);
        n = 0;
        while (preboot_out === 1'b1 && n < 100) begin
            @(posedge clk_in);
            #1 n++;
        end
        chk(n, 32);
    endtask : boot
    initial begin
        repeat (10) @(posedge clk_in);
        nrst_in <= 1'b1;
        boot();
        rd(OFS_PWR_CTRL, 32'h0);
        rd(16'h1234, 32'h0);
        wr(OFS_PWR_CTRL, 32'h61);
        @(posedge clk_in);
        #1 chk({22'h0, gate_out}, 32'h3f7);
        wr(OFS_PWR_CTRL, 32'h1e);
        @(posedge clk_in);
        #1 chk({22'h0, gate_out}, 32'h00c);
        wr(OFS_FUSE_SEL, 32'h4);
        rd(OFS_FUSE_VAL, 32'h5);
        wr(OFS_FUSE_SEL, 32'h5);
        rd(OFS_FUSE_VAL, 32'ha5);
        wr(OFS_FUSE_SEL, 32'h6);
        rd(OFS_FUSE_VAL, 32'h3c);
        wr(OFS_COMP_MODE, COMP_EXTERNAL);
        wr(OFS_GAIN_ADJUST_WORD, 32'h0012_3456);
        rd(OFS_GAIN_ADJUST_WORD, 32'h0012_3456);
        wr(OFS_PWR_CTRL, 32'h200);
        mux();
        chk(32'(chop_reversed_out), 32'h1);
        wr(OFS_PWR_CTRL, 32'h100);
        mux();
        chk(32'(chop_reversed_out), 32'h0);
        wr(OFS_PWR_CTRL, 32'h300);
        mux();
        p = chop_reversed_out;
        mux();
        chk(32'(chop_reversed_out ^ p), 32'h1);
        wr(OFS_PWR_CTRL, 32'h080);
        mux();
        chk({alt_cycle_out, chop_reversed_out}, 32'h2);
        // Both busy lines fall together; both irqs must be high together in exactly one cycle
        engine_busy_in <= 1'b1;
        transfer_busy_in <= 1'b1;
        @(posedge clk_in);
        engine_busy_in <= 1'b0;
        transfer_busy_in <= 1'b0;
        n = 0;
        repeat (4) begin
            @(posedge clk_in);
            #1 n += 32'({engine_irq_out, transfer_irq_out} === 2'b11);
        end
        chk(n, 1);
        // Divider 3: one tick every four cycles
        wr(OFS_PWR_CTRL, 32'h3000);
        n = 0;
        repeat (8) begin
            @(posedge clk_in);
            #1 n += int'(cpu_clk_tick_out);
        end
        chk(n, 2);
        // Watchdog flag must survive the chip reset below
        @(posedge clk_in);
        watchdog_overflow_in <= 1'b1;
        @(posedge clk_in);
        watchdog_overflow_in <= 1'b0;
        // Pin drop, then restart while the timer is counting
        wr(OFS_PWR_CTRL, 32'h61);
        ext_reset_low_pin_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1 chk({digital_halt_out, cpu_reset_out}, 32'h3);
        ext_reset_low_pin_n_in <= 1'b1;
        repeat (24) @(posedge clk_in);
        ext_reset_low_pin_n_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        ext_reset_low_pin_n_in <= 1'b1;
        boot();
        rd(OFS_PWR_CTRL, 32'h0);
        chk(32'(watchdog_overflow_flag_out), 32'h1);
        power_fault_above_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1 chk({digital_halt_out, battery_hold_out}, 32'h3);
        power_fault_above_in <= 1'b1;
        boot();
        final_report();
    end
endmodule : tb_top
